//--- src/rtc_trim_alarm_pkg.sv
package rtc_trim_alarm_pkg;
  localparam logic [3:0] ADDR_TRIM = 4'h7;
  localparam logic [3:0] ADDR_WEEKLY_MINUTE = 4'h8;
  localparam logic [3:0] ADDR_WEEKLY_HOUR = 4'h9;
  localparam logic [3:0] ADDR_WEEKLY_DAY_MASK = 4'ha;
  localparam logic [3:0] ADDR_DAILY_MINUTE = 4'hb;
  localparam logic [3:0] ADDR_DAILY_HOUR = 4'hc;
  localparam logic [7:0] MASK_SEVEN_BITS = 8'h7f;
  localparam logic [7:0] MASK_SIX_BITS = 8'h3f;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int TRIM_SIGN_POS = 6;
  localparam int HOUR_PM_POS = 5;
  localparam logic [6:0] SECONDS_00 = 7'h00;
  localparam logic [6:0] SECONDS_20 = 7'h20;
  localparam logic [6:0] SECONDS_40 = 7'h40;
  localparam logic [5:0] TRIM_MAG_NONE = 6'h00;
  localparam logic [5:0] TRIM_MAG_ONE = 6'h01;
  localparam int DIV_NOMINAL_COUNT = 32768;
  localparam int DIV_WIDTH = 17;
  localparam int WEEKDAYS = 7;
endpackage : rtc_trim_alarm_pkg

//--- src/rtc_alarm_and_trim.sv
`timescale 1ns/1ps
// Contract
// (RULE_01) trim only at seconds 00, 20, 40; setting 0000111 adds twelve pulses
// (RULE_02) setting 0000001 leaves the adjusted second at nominal length
// (RULE_03) setting 1111110 shortens the adjusted second by four pulses
// (RULE_04) trim changes pulses counted per second, not oscillator rate
// (RULE_05) weekly minute holds seven BCD bits; bit 7 reads zero
// (RULE_06) weekly hour holds six BCD bits; bits 7 and 6 read zero
// (RULE_07) weekly hour bit 5 is PM flag or hour-tens twenty bit
// (RULE_08) weekly day mask holds seven enables; bit 7 reads zero
// (RULE_09) enable bit n matches weekday counter value n, values 0 to 6
// (RULE_10) all day enables clear means the weekly alarm never matches
// (RULE_11) twelve-hour midnight is BCD 12, noon is BCD 32
// (RULE_12) daily minute holds seven BCD bits; bit 7 reads zero
// (RULE_13) daily hour holds six BCD bits; bit 5 is PM or twenty bit
// (RULE_14) after oscillation halt alarm fields are indefinite; unused bits read zero
// (RULE_15) host programs only alarm times that can occur; test_regs writes 8'hff to every alarm register
// (RULE_16) positive trim adds 2*(mag-1); negative removes 2*(inverted mag+1)
// (RULE_17) untrimmed, one second tick per 32768 oscillator pulses
// (RULE_18) weekly match on minute, hour, weekday enable; daily on minute, hour
// (RULE_19) trim applies once per qualifying second, not in the write's second
module rtc_alarm_and_trim #(
  parameter int DIV_NOMINAL = rtc_trim_alarm_pkg::DIV_NOMINAL_COUNT
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic [6:0] i_current_seconds,
  input wire logic [6:0] i_current_minute,
  input wire logic [5:0] i_current_hour,
  input wire logic [2:0] i_weekday_counter_bits,
  input wire logic i_oscillation_halt_flag,
  output logic [7:0] o_reg_rdata,
  output logic o_second_tick,
  output logic o_weekly_match,
  output logic o_daily_match
);

  localparam int DW = rtc_trim_alarm_pkg::DIV_WIDTH;

  // the shortest trimmed second must stay well above zero
  if (DIV_NOMINAL < 256 || DIV_NOMINAL > 65536)
  begin : g_bad_nominal
    $error("DIV_NOMINAL out of range");
  end
  // the divider must still hold the longest trimmed second
  if (DIV_NOMINAL + 124 >= (1 << DW))
  begin : g_bad_width
    $error("divider too narrow for DIV_NOMINAL");
  end
  if (rtc_trim_alarm_pkg::WEEKDAYS != 7)
  begin : g_bad_weekdays
    $error("day mask logic serves seven weekdays only");
  end

  typedef struct packed {
    logic [6:0] trim;
    logic trim_written_this_second;
    logic [6:0] weekly_alarm_minute_field;
    logic [5:0] weekly_alarm_hour;
    logic [6:0] weekly_alarm_day_enables;
    logic [6:0] daily_alarm_minute_field;
    logic [5:0] daily_alarm_hour;
    logic [DW-1:0] divider;
    logic [7:0] rdata;
    logic second_tick;
    logic weekly_match;
    logic daily_match;
  } state_s;

  state_s state;
  state_s next_state;

  logic trim_sign_bit;
  logic [5:0] trim_magnitude_field;
  logic trim_is_zero;
  logic seconds_on_trim_slot;
  logic qualifying_second;
  logic signed [DW:0] lengthen_count;
  logic signed [DW:0] shorten_count;
  logic signed [DW:0] trim_adjust;
  logic signed [DW:0] terminal_count;
  logic end_of_second;

  logic write_trim;
  logic write_weekly_minute;
  logic write_weekly_hour;
  logic write_weekly_day_mask;
  logic write_daily_minute;
  logic write_daily_hour;
  logic [7:0] read_value;

  logic [6:0] day_hit;
  logic day_enabled;
  logic alarms_valid;
  logic weekly_minute_equal;
  logic weekly_hour_equal;
  logic daily_minute_equal;
  logic daily_hour_equal;
  logic next_weekly_match;
  logic next_daily_match;

  assign trim_sign_bit = state.trim[rtc_trim_alarm_pkg::TRIM_SIGN_POS];
  assign trim_magnitude_field = state.trim[5:0];
  // a zero magnitude means no trim whatever the sign bit says
  assign trim_is_zero = trim_magnitude_field == rtc_trim_alarm_pkg::TRIM_MAG_NONE; // RULE_02
  assign seconds_on_trim_slot = i_current_seconds == rtc_trim_alarm_pkg::SECONDS_00
    || i_current_seconds == rtc_trim_alarm_pkg::SECONDS_20
    || i_current_seconds == rtc_trim_alarm_pkg::SECONDS_40; // RULE_01

  // a trim written during a qualifying second waits for the next one
  assign qualifying_second = seconds_on_trim_slot
    && !state.trim_written_this_second; // RULE_19

  // setting one is neutral, each step above it adds two pulses
  assign lengthen_count = (DW+1)'(signed'({1'b0, trim_magnitude_field}
    - {1'b0, rtc_trim_alarm_pkg::TRIM_MAG_ONE})) <<< 1; // RULE_16

  // a set sign bit makes the field a two's complement step count
  assign shorten_count = (DW+1)'({1'b0, ~trim_magnitude_field}
    + {1'b0, rtc_trim_alarm_pkg::TRIM_MAG_ONE}) <<< 1; // RULE_16

  always_comb
  begin
    trim_adjust = '0;
    if (qualifying_second && !trim_is_zero)
    begin
      if (!trim_sign_bit)
      begin
        trim_adjust = lengthen_count; // RULE_01 RULE_02 RULE_16
      end
      else
      begin
        trim_adjust = -shorten_count; // RULE_03 RULE_16
      end
    end
  end

  // only the count length moves; the pulse stream itself is untouched
  assign terminal_count = (DW+1)'(DIV_NOMINAL) + trim_adjust - (DW+1)'(1); // RULE_04 RULE_17
  // seconds must hold still within a second, or the length chosen here shifts
  assign end_of_second = {1'b0, state.divider} >= terminal_count; // RULE_17

  // unmapped addresses raise no strobe, so such writes simply vanish
  always_comb
  begin
    write_trim = 1'b0;
    write_weekly_minute = 1'b0;
    write_weekly_hour = 1'b0;
    write_weekly_day_mask = 1'b0;
    write_daily_minute = 1'b0;
    write_daily_hour = 1'b0;
    if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_TRIM)
    begin
      write_trim = i_reg_write;
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_WEEKLY_MINUTE)
    begin
      write_weekly_minute = i_reg_write;
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_WEEKLY_HOUR)
    begin
      write_weekly_hour = i_reg_write;
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_WEEKLY_DAY_MASK)
    begin
      write_weekly_day_mask = i_reg_write;
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_DAILY_MINUTE)
    begin
      write_daily_minute = i_reg_write;
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_DAILY_HOUR)
    begin
      write_daily_hour = i_reg_write;
    end
  end

  // unused high bits are never stored, so they always read zero
  // read data lags the address by one enabled edge
  always_comb
  begin
    read_value = rtc_trim_alarm_pkg::RESET_VALUE;
    if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_TRIM)
    begin
      read_value = {1'b0, state.trim};
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_WEEKLY_MINUTE)
    begin
      read_value = {1'b0, state.weekly_alarm_minute_field}; // RULE_05 RULE_14
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_WEEKLY_HOUR)
    begin
      read_value = {2'b00, state.weekly_alarm_hour}; // RULE_06 RULE_14
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_WEEKLY_DAY_MASK)
    begin
      read_value = {1'b0, state.weekly_alarm_day_enables}; // RULE_08 RULE_14
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_DAILY_MINUTE)
    begin
      read_value = {1'b0, state.daily_alarm_minute_field}; // RULE_12 RULE_14
    end
    else if (i_reg_addr == rtc_trim_alarm_pkg::ADDR_DAILY_HOUR)
    begin
      read_value = {2'b00, state.daily_alarm_hour}; // RULE_13 RULE_14
    end
  end

  // one comparator per enable bit; weekday value seven owns no bit and never matches
  for (genvar day = 0; day < rtc_trim_alarm_pkg::WEEKDAYS; day++)
  begin : g_day
    assign day_hit[day] = state.weekly_alarm_day_enables[day]
      && i_weekday_counter_bits == 3'(day); // RULE_09
  end
  assign day_enabled = |day_hit; // RULE_10

  // the halt flag marks the alarm fields as unknown, so no match is trusted then
  assign alarms_valid = !i_oscillation_halt_flag; // RULE_14
  // bit 5 compares as stored, so PM flag and twenty bit both work; midnight is 12, noon 32
  assign weekly_minute_equal = i_current_minute == state.weekly_alarm_minute_field; // RULE_18
  assign weekly_hour_equal = i_current_hour == state.weekly_alarm_hour; // RULE_07 RULE_11
  assign daily_minute_equal = i_current_minute == state.daily_alarm_minute_field; // RULE_18
  assign daily_hour_equal = i_current_hour == state.daily_alarm_hour; // RULE_13 RULE_11

  always_comb
  begin
    next_weekly_match = 1'b0;
    next_daily_match = 1'b0;
    if (alarms_valid && weekly_minute_equal && weekly_hour_equal)
    begin
      next_weekly_match = day_enabled; // RULE_18 RULE_10
    end
    if (alarms_valid && daily_minute_equal && daily_hour_equal)
    begin
      next_daily_match = 1'b1; // RULE_18
    end
  end

  always_comb
  begin
    next_state = state;
    next_state.second_tick = 1'b0;
    if (end_of_second)
    begin
      next_state.divider = '0;
      next_state.second_tick = 1'b1; // RULE_17
      next_state.trim_written_this_second = 1'b0; // RULE_19
    end
    else
    begin
      next_state.divider = state.divider + DW'(1);
    end
    // a trim write on the last cycle of a second marks the next second: the set wins
    if (write_trim)
    begin
      next_state.trim = i_reg_wdata[6:0];
      next_state.trim_written_this_second = 1'b1; // RULE_19
    end
    if (write_weekly_minute)
    begin
      next_state.weekly_alarm_minute_field = i_reg_wdata[6:0]; // RULE_05
    end
    if (write_weekly_hour)
    begin
      next_state.weekly_alarm_hour = i_reg_wdata[5:0]; // RULE_06 RULE_07
    end
    if (write_weekly_day_mask)
    begin
      next_state.weekly_alarm_day_enables = i_reg_wdata[6:0]; // RULE_08
    end
    if (write_daily_minute)
    begin
      next_state.daily_alarm_minute_field = i_reg_wdata[6:0]; // RULE_12
    end
    if (write_daily_hour)
    begin
      next_state.daily_alarm_hour = i_reg_wdata[5:0]; // RULE_13
    end
    next_state.rdata = read_value;
    next_state.weekly_match = next_weekly_match;
    next_state.daily_match = next_daily_match;
  end

  // low enable freezes every bit of state, divider included
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      state <= '0;
    else if (i_enable)
      state <= next_state;
  end

  assign o_reg_rdata = state.rdata;
  assign o_second_tick = state.second_tick;
  assign o_weekly_match = state.weekly_match;
  assign o_daily_match = state.daily_match;

endmodule : rtc_alarm_and_trim

//--- verification/rtc_alarm_and_trim_properties.sv
`timescale 1ns/1ps
module rtc_alarm_and_trim_properties #(
  parameter int DIV_NOMINAL = 256
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_enable,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic [6:0] i_current_seconds,
  input wire logic [6:0] i_current_minute,
  input wire logic [5:0] i_current_hour,
  input wire logic [2:0] i_weekday_counter_bits,
  input wire logic i_oscillation_halt_flag,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_second_tick,
  input wire logic o_weekly_match,
  input wire logic o_daily_match
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  int gap;
  // enabled edges since the last tick; trim can move it by at most -126..+124
  always_ff @(posedge i_clock)
    if (i_reset) gap <= 0;
    else if (i_enable) gap <= o_second_tick ? 1 : gap + 1;
  property wr_rd;
    logic [7:0] d;
    (i_enable && i_reg_write && i_reg_addr == 4'hb, d = i_reg_wdata) ##1
    (i_enable && !i_reg_write && i_reg_addr == 4'hb) |=> o_reg_rdata == {1'b0, d[6:0]};
  endproperty
  AST_TICK_GAP: assert property ($rose(o_second_tick) |->
    gap >= DIV_NOMINAL - 128 && gap <= DIV_NOMINAL + 124) else $error("second length off");
  AST_TICK_PULSE: assert property (o_second_tick && i_enable |=> !o_second_tick)
    else $error("tick wider than one cycle");
  AST_BIT7_ZERO: assert property (!o_reg_rdata[7]) else $error("bit 7 read high");
  AST_HOUR_TOP: assert property (i_enable && i_reg_addr inside {4'h9, 4'hc} |=>
    o_reg_rdata[7:6] == 2'h0) else $error("hour top bits read high");
  AST_DAILY_MIN_RB: assert property (wr_rd) else $error("daily minute readback");
  AST_HALT_QUIET: assert property (i_enable && i_oscillation_halt_flag |=>
    !o_weekly_match && !o_daily_match) else $error("match while halted");
  AST_WDAY7: assert property (i_enable && i_weekday_counter_bits == 3'h7 |=>
    !o_weekly_match) else $error("weekly match on weekday 7");
  AST_WEEKLY_HOLD: assert property (o_weekly_match && i_enable && !i_reg_write &&
    !$past(i_reg_write) && $stable(i_current_minute) && $stable(i_current_hour) &&
    $stable(i_weekday_counter_bits) && !i_oscillation_halt_flag |=> o_weekly_match)
    else $error("weekly match dropped");
  cover property (o_weekly_match);
  cover property (o_daily_match);
  cover property ($rose(o_second_tick));
endmodule : rtc_alarm_and_trim_properties

//--- verification/rtc_host_model.sv
`timescale 1ns/1ps
module rtc_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_rdata,
  output logic [3:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_write
);
  initial {o_addr, o_wdata, o_write} = '0;
  // callers pass only alarm times that can occur, except test_regs, which writes 8'hff to every register
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    o_wdata <= d;
    o_write <= 1'b1;
    @(posedge i_clock);
    o_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    o_addr <= a;
    repeat (2) @(posedge i_clock);
    #1 d = i_rdata;
  endtask : rd
endmodule : rtc_host_model

//--- verification/rtc_alarm_and_trim_tb_top.sv
`timescale 1ns/1ps
module rtc_alarm_and_trim_tb_top;
  localparam int N = 256;
  logic clk = 0, rst = 1, en = 1, halt = 0, wr, tick, wm, dm;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [6:0] sec = 7'h01, min = 7'h00;
  logic [5:0] hr = 6'h00;
  logic [2:0] wday = 3'h0;
  int fail_count = 0, num_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  rtc_host_model host (.i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_write(wr));
  rtc_alarm_and_trim #(.DIV_NOMINAL(N)) uut (.i_clock(clk), .i_reset(rst), .i_enable(en),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr), .i_current_seconds(sec),
    .i_current_minute(min), .i_current_hour(hr), .i_weekday_counter_bits(wday),
    .i_oscillation_halt_flag(halt), .o_reg_rdata(rdata), .o_second_tick(tick),
    .o_weekly_match(wm), .o_daily_match(dm));
  task automatic chk(input string s, input logic [31:0] got, exp);
    num_checks++;
    fail_count += int'(got !== exp);
    if (got !== exp) $display("[FAIL] %s exp %0h got %0h", s, exp, got);
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic to_tick;
    int i = 0;
    do @(posedge clk) #1; while (tick !== 1'b1 && ++i < 3 * N);
    chk("tick", 32'(tick), 1);
    if (tick !== 1'b1) give_verdict();
  endtask : to_tick
  task automatic test_regs;
    logic [7:0] v;
    for (int a = 7; a < 14; a++)
    begin
      host.wr(a[3:0], 8'hff);
      host.rd(a[3:0], v);
      chk("reg", 32'(v), a == 13 ? 0 : (a == 9 || a == 12) ? 'h3f : 'h7f);
    end
    $display("test_regs done");
  endtask : test_regs
  task automatic step(input logic [6:0] m, input logic [5:0] h, input logic [2:0] w,
    input logic hl, input logic ew, input logic ed);
    @(posedge clk);
    {min, hr, wday, halt} <= {m, h, w, hl};
    repeat (3) @(posedge clk);
    #1 chk("weekly", 32'(wm), 32'(ew));
    chk("daily", 32'(dm), 32'(ed));
  endtask : step
  task automatic test_alarm;
    host.wr(4'h8, 8'h30);
    host.wr(4'h9, 8'h32);
    host.wr(4'ha, 8'h02);
    host.wr(4'hb, 8'h59);
    host.wr(4'hc, 8'h23);
    step(7'h30, 6'h32, 3'h1, 1'b0, 1'b1, 1'b0);
    step(7'h30, 6'h32, 3'h2, 1'b0, 1'b0, 1'b0);
    step(7'h59, 6'h23, 3'h7, 1'b0, 1'b0, 1'b1);
    step(7'h59, 6'h23, 3'h1, 1'b1, 1'b0, 1'b0);
    host.wr(4'ha, 8'h7f);
    step(7'h30, 6'h32, 3'h7, 1'b0, 1'b0, 1'b0);
    step(7'h30, 6'h32, 3'h6, 1'b0, 1'b1, 1'b0);
    host.wr(4'hc, 8'h12);
    step(7'h59, 6'h12, 3'h0, 1'b0, 1'b0, 1'b1);
    host.wr(4'ha, 8'h00);
    step(7'h30, 6'h32, 3'h1, 1'b0, 1'b0, 1'b0);
    $display("test_alarm done");
  endtask : test_alarm
  task automatic test_hold;
    logic [7:0] v;
    host.wr(4'h8, 8'h12);
    @(posedge clk) en <= 1'b0;
    host.wr(4'h8, 8'h34);
    @(posedge clk) en <= 1'b1;
    host.rd(4'h8, v);
    chk("frozen write", 32'(v), 'h12);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    host.rd(4'h8, v);
    chk("reset clears", 32'(v), 0);
    $display("test_hold done");
  endtask : test_hold
  task automatic test_trim;
    logic [6:0] s [4] = '{7'h01, 7'h00, 7'h20, 7'h40};
    logic [6:0] t [4] = '{7'h07, 7'h07, 7'h01, 7'h7e};
    int d [4] = '{0, 12, 0, -4};
    int t0;
    for (int k = 0; k < 4; k++)
    begin
      to_tick();
      @(posedge clk) sec <= s[k];
      host.wr(4'h7, {1'b0, t[k]});
      to_tick();
      t0 = cyc;
      to_tick();
      chk("second", 32'(cyc - t0), 32'(N + d[k]));
    end
    $display("test_trim done");
  endtask : test_trim
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_regs();
    test_alarm();
    test_hold();
    test_trim();
    give_verdict();
  end
endmodule : rtc_alarm_and_trim_tb_top
bind rtc_alarm_and_trim rtc_alarm_and_trim_properties #(.DIV_NOMINAL(DIV_NOMINAL)) props (.*);
